// file: core/ebz_pkg.sv
package ebz_pkg;
   localparam int ZONES = 3;
   localparam int ZW = 2;
   localparam int EXT_AW = 19;
   localparam int EXT_DW = 16;
   localparam int CW = 5;
   localparam int WSW = 8;

   // Register byte addresses on the plain register port.
   localparam logic [7:0] REG_ZONE_BASE = 8'h00;
   localparam logic [7:0] REG_CLKCFG = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;

   // Field positions inside each zone_phase_timing_reg.
   localparam int F_WR_TRAIL = 0;
   localparam int F_WR_ACT = 2;
   localparam int F_WR_LEAD = 5;
   localparam int F_RD_TRAIL = 7;
   localparam int F_RD_ACT = 9;
   localparam int F_RD_LEAD = 12;
   localparam int F_READY_USE = 14;
   localparam int F_READY_ASYNC = 15;
   localparam int F_DOUBLE = 16;
   localparam logic [31:0] TIMING_MASK = 32'h0001_ffff;
   localparam logic [31:0] TIMING_RESET = 32'h0001_3fff;

   // Clock configuration bits.
   localparam int F_TIM_HALF = 0;
   localparam int F_XCLK_HALF = 1;
   localparam logic [1:0] CLKCFG_RESET = 2'h0;

   // Status layout.
   localparam int F_ST_BUSY = 4;
   localparam int F_ST_WS = 8;

   localparam logic [EXT_AW-1:0] ADDR_RESET = 19'h00001;
   localparam logic [CW-1:0] CNT_LAST = 5'h01;

   typedef enum logic [3:0] {
      EBZ_IDLE = 4'h1,
      EBZ_LEAD = 4'h2,
      EBZ_ACT = 4'h4,
      EBZ_TRAIL = 4'h8
   } ebz_phase_t;

   function automatic logic [CW-1:0] ebz_scale(input logic [2:0] v, input logic dbl);
      ebz_scale = dbl ? {1'b0, v, 1'b0} : {2'b00, v};
   endfunction
endpackage

// file: core/ebz_tick_if.sv
`timescale 1ns/10ps
interface ebz_tick_if;
   logic tim_half;
   logic xclk_half;
   logic tim_en;
   logic xclk;
   modport gen (input tim_half, input xclk_half, output tim_en, output xclk);
   modport use_side (output tim_half, output xclk_half, input tim_en, input xclk);
endinterface

// file: core/ebz_tick_gen.sv
`timescale 1ns/10ps
module ebz_tick_gen
   import ebz_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   ebz_tick_if.gen tk
);
   // The timing clock is ref_clk/2 or ref_clk/4, so an equal-rate bus clock
   // can still be built from flops with a clean high and low half.
   logic [2:0] div_cnt;
   logic [2:0] next_div_cnt;
   logic [1:0] tim_mask;
   logic [1:0] xsel;

   always_comb begin
      next_div_cnt = div_cnt + 3'h1;
      tim_mask = tk.tim_half ? 2'h3 : 2'h1;
      xsel = 2'(tk.tim_half) + 2'(tk.xclk_half);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         div_cnt <= 3'h0;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tk.tim_en <= 1'b0;
         tk.xclk <= 1'b0;
      end else begin
         tk.tim_en <= (next_div_cnt[1:0] & tim_mask) == tim_mask;
         tk.xclk <= ~next_div_cnt[xsel];
      end
   end
endmodule

// file: core/ebz_zone_timer.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Every access runs lead, then active, then trail phase; a zero lead or trail setting skips that phase.
// - Each zone owns a timing register applied to its own accesses.
// - Read lead lasts setting ticks, doubled when doubling is on.
// - Read active lasts setting (doubled if on) plus wait states plus one.
// - Read trail lasts setting ticks, doubled when doubling is on.
// - Writes use the same formulas with the write settings.
// - With ready ignored no wait states are ever inserted.
// - Strobes and chip selects change only on timing clock ticks.
// - Bus clock output equals timing clock or half of it.
// - Between accesses address holds, lowest address bit stays high.
module ebz_zone_timer
   import ebz_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic acc_valid,
   output logic acc_ready,
   input wire logic acc_write,
   input wire logic [ZW-1:0] acc_zone,
   input wire logic [EXT_AW-1:0] acc_addr,
   input wire logic [1:0] acc_be,
   input wire logic [EXT_DW-1:0] acc_wdata,
   output logic acc_done,
   output logic [EXT_DW-1:0] acc_rdata,
   output logic [EXT_AW-1:0] ext_addr,
   output logic [EXT_DW-1:0] ext_data_out,
   output logic ext_data_oe,
   input wire logic [EXT_DW-1:0] ext_data_in,
   output logic [ZONES-1:0] zone_chip_select_n,
   output logic read_strobe_n,
   output logic write_strobe_lo_n,
   output logic write_strobe_hi_n,
   input wire logic ext_ready_in,
   output logic ext_bus_clock_out
);
   ebz_tick_if tk ();
   logic [31:0] zone_phase_timing_reg [ZONES];
   logic [1:0] clk_cfg;
   ebz_phase_t state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic [WSW-1:0] hw_wait_states;
   logic pend, wr_q;
   logic [ZW-1:0] zone_q;
   logic [1:0] be_q;
   logic [EXT_AW-1:0] addr_q;
   logic rdy_s1, rdy_s2, rdy_s3, ready_ok;
   logic [EXT_DW-1:0] din_s1, din_s2;
   logic [31:0] cfg;
   logic phase_doubling, ready_input_use, ready_sampling_async;
   logic [CW-1:0] lead_len, act_len, trail_len;
   logic is_wait;
   logic [1:0] rd_cap_q, done_q;
   assign tk.tim_half = clk_cfg[F_TIM_HALF];
   assign tk.xclk_half = clk_cfg[F_XCLK_HALF];
   assign ext_bus_clock_out = tk.xclk;
   ebz_tick_gen u_tick (
      .ref_clk(ref_clk),
      .reset(reset),
      .tk(tk)
   );
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         clk_cfg <= CLKCFG_RESET;
         for (int i = 0; i < ZONES; i++) begin
            zone_phase_timing_reg[i] <= TIMING_RESET;
         end
      end else if (reg_wr) begin
         if (reg_addr == REG_CLKCFG) begin
            clk_cfg <= reg_wdata[1:0];
         end
         for (int i = 0; i < ZONES; i++) begin
            if (reg_addr == REG_ZONE_BASE + 8'(4 * i)) begin
               zone_phase_timing_reg[i] <= reg_wdata & TIMING_MASK;
            end
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            if (reg_addr == REG_CLKCFG) begin
               reg_rdata <= {30'h0, clk_cfg};
            end else if (reg_addr == REG_STATUS) begin
               reg_rdata <= {16'h0, hw_wait_states, 3'h0, state != EBZ_IDLE, state};
            end
            for (int i = 0; i < ZONES; i++) begin
               if (reg_addr == REG_ZONE_BASE + 8'(4 * i)) begin
                  reg_rdata <= zone_phase_timing_reg[i];
               end
            end
         end
      end
   end
   // Asynchronous mode adds a third flop for settling, at one more cycle of ready delay.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
         rdy_s3 <= 1'b0;
         din_s1 <= '0;
         din_s2 <= '0;
      end else begin
         rdy_s1 <= ext_ready_in;
         rdy_s2 <= rdy_s1;
         rdy_s3 <= rdy_s2;
         din_s1 <= ext_data_in;
         din_s2 <= din_s1;
      end
   end
   always_comb begin
      cfg = zone_phase_timing_reg[zone_q];
      phase_doubling = cfg[F_DOUBLE];
      ready_input_use = cfg[F_READY_USE];
      ready_sampling_async = cfg[F_READY_ASYNC];
      ready_ok = ready_sampling_async ? rdy_s3 : rdy_s2;
      if (wr_q) begin
         lead_len = ebz_scale({1'b0, cfg[F_WR_LEAD +: 2]}, phase_doubling);
         act_len = ebz_scale(cfg[F_WR_ACT +: 3], phase_doubling) + CNT_LAST;
         trail_len = ebz_scale({1'b0, cfg[F_WR_TRAIL +: 2]}, phase_doubling);
      end else begin
         lead_len = ebz_scale({1'b0, cfg[F_RD_LEAD +: 2]}, phase_doubling);
         act_len = ebz_scale(cfg[F_RD_ACT +: 3], phase_doubling) + CNT_LAST;
         trail_len = ebz_scale({1'b0, cfg[F_RD_TRAIL +: 2]}, phase_doubling);
      end
   end
   assign acc_ready = (state == EBZ_IDLE) && !pend && (acc_zone < ZW'(ZONES));
   // Phases advance only on timing clock ticks; a zero lead or trail setting skips that phase.
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      is_wait = 1'b0;
      if (tk.tim_en) begin
         unique case (state)
            EBZ_IDLE: begin
               if (pend) begin
                  if (lead_len != '0) begin
                     next_state = EBZ_LEAD;
                     next_cnt = lead_len;
                  end else begin
                     next_state = EBZ_ACT;
                     next_cnt = act_len;
                  end
               end
            end
            EBZ_LEAD: begin
               if (cnt == CNT_LAST) begin
                  next_state = EBZ_ACT;
                  next_cnt = act_len;
               end else begin
                  next_cnt = cnt - CNT_LAST;
               end
            end
            EBZ_ACT: begin
               if (cnt != CNT_LAST) begin
                  next_cnt = cnt - CNT_LAST;
               end else if (ready_input_use && !ready_ok) begin
                  is_wait = 1'b1;
               end else if (trail_len != '0) begin
                  next_state = EBZ_TRAIL;
                  next_cnt = trail_len;
               end else begin
                  next_state = EBZ_IDLE;
               end
            end
            EBZ_TRAIL: begin
               if (cnt == CNT_LAST) begin
                  next_state = EBZ_IDLE;
               end else begin
                  next_cnt = cnt - CNT_LAST;
               end
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= EBZ_IDLE;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pend <= 1'b0;
         wr_q <= 1'b0;
         zone_q <= '0;
         be_q <= 2'h0;
         addr_q <= ADDR_RESET;
         ext_data_out <= '0;
      end else if (acc_valid && acc_ready) begin
         pend <= 1'b1;
         wr_q <= acc_write;
         zone_q <= acc_zone;
         be_q <= acc_be;
         addr_q <= acc_addr;
         ext_data_out <= acc_wdata;
      end else if (state == EBZ_IDLE && next_state != EBZ_IDLE) begin
         pend <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hw_wait_states <= '0;
      end else if (state == EBZ_IDLE && next_state != EBZ_IDLE) begin
         hw_wait_states <= '0;
      end else if (is_wait && hw_wait_states != '1) begin
         hw_wait_states <= hw_wait_states + WSW'(1);
      end
   end
   // Pins are registered from the next phase so they move with the tick edge.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         zone_chip_select_n <= '1;
         read_strobe_n <= 1'b1;
         write_strobe_lo_n <= 1'b1;
         write_strobe_hi_n <= 1'b1;
         ext_data_oe <= 1'b0;
      end else begin
         zone_chip_select_n <= (next_state != EBZ_IDLE) ? ~(ZONES'(1) << zone_q) : '1;
         read_strobe_n <= !(next_state == EBZ_ACT && !wr_q);
         write_strobe_lo_n <= !(next_state == EBZ_ACT && wr_q && be_q[0]);
         write_strobe_hi_n <= !(next_state == EBZ_ACT && wr_q && be_q[1]);
         ext_data_oe <= (next_state != EBZ_IDLE) && wr_q;
      end
   end
   // Pin data lag two cycles in the synchroniser, so capture and done wait for them.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ext_addr <= ADDR_RESET;
         acc_rdata <= '0;
         acc_done <= 1'b0;
         rd_cap_q <= 2'h0;
         done_q <= 2'h0;
      end else begin
         done_q <= {done_q[0], (state != EBZ_IDLE) && (next_state == EBZ_IDLE)};
         acc_done <= done_q[1];
         if (state == EBZ_IDLE && next_state != EBZ_IDLE) begin
            ext_addr <= addr_q;
         end else if (state != EBZ_IDLE && next_state == EBZ_IDLE) begin
            ext_addr[0] <= 1'b1;
         end
         rd_cap_q <= {rd_cap_q[0], state == EBZ_ACT && next_state != EBZ_ACT && !wr_q};
         if (rd_cap_q[1]) begin
            acc_rdata <= din_s2;
         end
      end
   end
   logic [WSW-1:0] ph_ticks;
   always_ff @(posedge ref_clk) begin
      if (reset || next_state != state) begin
         ph_ticks <= '0;
      end else if (tk.tim_en) begin
         ph_ticks <= ph_ticks + WSW'(1);
      end
   end
   lead_length_a: assert property (@(posedge ref_clk) disable iff (reset)
      state == EBZ_LEAD && next_state != EBZ_LEAD |-> ph_ticks + WSW'(1) == WSW'(lead_len))
      else $error("lead phase length wrong");
   active_length_a: assert property (@(posedge ref_clk) disable iff (reset)
      state == EBZ_ACT && next_state != EBZ_ACT
      |-> ph_ticks + WSW'(1) == WSW'(act_len) + hw_wait_states)
      else $error("active phase length wrong");
   trail_length_a: assert property (@(posedge ref_clk) disable iff (reset)
      state == EBZ_TRAIL && next_state != EBZ_TRAIL |-> ph_ticks + WSW'(1) == WSW'(trail_len))
      else $error("trail phase length wrong");
   no_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
      state == EBZ_ACT && !ready_input_use |-> hw_wait_states == '0)
      else $error("wait state with ready ignored");
   tick_only_a: assert property (@(posedge ref_clk) disable iff (reset)
      !$stable(state) |-> $past(tk.tim_en))
      else $error("phase moved off a tick");
   strobe_active_a: assert property (@(posedge ref_clk) disable iff (reset)
      !read_strobe_n || !write_strobe_lo_n || !write_strobe_hi_n |-> state == EBZ_ACT)
      else $error("strobe outside active phase");
   cs_span_a: assert property (@(posedge ref_clk) disable iff (reset)
      state != EBZ_IDLE |-> zone_chip_select_n == ~(ZONES'(1) << zone_q))
      else $error("chip select not held for access");
   addr_lsb_a: assert property (@(posedge ref_clk) disable iff (reset)
      state == EBZ_IDLE |-> ext_addr[0] && $stable(ext_addr[EXT_AW-1:1]))
      else $error("address not held between accesses");
endmodule

// file: dv/ebz_mem_model.sv
`timescale 1ns/10ps
module ebz_mem_model
   import ebz_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [EXT_AW-1:0] ext_addr,
   input wire logic [EXT_DW-1:0] ext_data_out,
   input wire logic [ZONES-1:0] zone_chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_lo_n,
   input wire logic write_strobe_hi_n,
   input wire logic [7:0] ready_hold,
   output logic [EXT_DW-1:0] ext_data_in,
   output logic ext_ready_in
);
   logic [EXT_DW-1:0] mem [16];
   logic [EXT_DW-1:0] last = 16'h0000;
   logic [7:0] wait_cnt = 8'h00;
   logic sel;
   logic strobing;
   assign sel = ~&zone_chip_select_n;
   assign strobing = ~(read_strobe_n & write_strobe_lo_n & write_strobe_hi_n);
   // A released data bus shows the inverse of the last value, so stale data cannot pass.
   assign ext_data_in = (sel && !read_strobe_n) ? mem[ext_addr[3:0]] : ~last;
   // Ready stays low for ready_hold cycles from the start of every strobe.
   assign ext_ready_in = !strobing || wait_cnt == 8'h00;
   always @(posedge ref_clk) begin
      if (!strobing) begin
         wait_cnt <= ready_hold;
      end else if (wait_cnt != 8'h00) begin
         wait_cnt <= wait_cnt - 8'h01;
      end
      if (sel && !read_strobe_n) begin
         last <= mem[ext_addr[3:0]];
      end
      if (sel && !write_strobe_lo_n) begin
         mem[ext_addr[3:0]][7:0] <= ext_data_out[7:0];
      end
      if (sel && !write_strobe_hi_n) begin
         mem[ext_addr[3:0]][15:8] <= ext_data_out[15:8];
      end
   end
endmodule

// file: dv/ext_bus_zone_access_timing_tb_top.sv
`timescale 1ns/10ps
module ext_bus_zone_access_timing_tb_top;
   import ebz_pkg::*;
   logic ref_clk, reset, reg_wr, reg_rd, acc_valid, acc_ready, acc_write, acc_done;
   logic [7:0] reg_addr, ready_hold;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [ZW-1:0] acc_zone;
   logic [EXT_AW-1:0] acc_addr, ext_addr, addr_seen;
   logic [1:0] acc_be;
   logic [EXT_DW-1:0] acc_wdata, acc_rdata, ext_data_out, ext_data_in;
   logic ext_data_oe, read_strobe_n, write_strobe_lo_n, write_strobe_hi_n;
   logic ext_ready_in, ext_bus_clock_out, oe_seen;
   logic [ZONES-1:0] zone_chip_select_n, cs_seen;
   int failures = 0;
   int checks_done = 0;
   int n_lead, n_act, n_trail;

   ebz_zone_timer dut (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_valid(acc_valid),
      .acc_ready(acc_ready), .acc_write(acc_write), .acc_zone(acc_zone),
      .acc_addr(acc_addr), .acc_be(acc_be), .acc_wdata(acc_wdata), .acc_done(acc_done),
      .acc_rdata(acc_rdata), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
      .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
      .zone_chip_select_n(zone_chip_select_n), .read_strobe_n(read_strobe_n),
      .write_strobe_lo_n(write_strobe_lo_n), .write_strobe_hi_n(write_strobe_hi_n),
      .ext_ready_in(ext_ready_in), .ext_bus_clock_out(ext_bus_clock_out)
   );
   ebz_mem_model far (
      .ref_clk(ref_clk), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
      .zone_chip_select_n(zone_chip_select_n), .read_strobe_n(read_strobe_n),
      .write_strobe_lo_n(write_strobe_lo_n), .write_strobe_hi_n(write_strobe_hi_n),
      .ready_hold(ready_hold), .ext_data_in(ext_data_in), .ext_ready_in(ext_ready_in)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Phase lengths are measured at the pins, in reference cycles.
   always @(posedge ref_clk) begin
      if (~&zone_chip_select_n) begin
         cs_seen <= zone_chip_select_n;
         oe_seen <= ext_data_oe;
         if (!(read_strobe_n && write_strobe_lo_n && write_strobe_hi_n)) begin
            n_act <= n_act + 1;
            addr_seen <= ext_addr;
         end else if (n_act == 0) begin
            n_lead <= n_lead + 1;
         end else begin
            n_trail <= n_trail + 1;
         end
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic access(input logic w, input logic [ZW-1:0] z, input logic [EXT_AW-1:0] a,
                         input logic [EXT_DW-1:0] d);
      int n;
      @(posedge ref_clk);
      n_lead <= 0;
      n_act <= 0;
      n_trail <= 0;
      acc_write <= w;
      acc_zone <= z;
      acc_addr <= a;
      acc_be <= 2'h3;
      acc_wdata <= d;
      acc_valid <= 1'b1;
      n = 0;
      #1;
      while (acc_ready !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1 n++;
      end
      @(posedge ref_clk);
      acc_valid <= 1'b0;
      #1;
      while (acc_done !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         #1 n++;
      end
      cmp({31'h0, acc_done}, 32'h1);
   endtask

   task automatic zone_test(input int z, l, a, t, ru, ra, dbl, hold, m);
      logic [31:0] cfg;
      logic [EXT_DW-1:0] d;
      logic [ZONES-1:0] ecs;
      int s;
      s = dbl + 1;
      ecs = ~(3'h1 << z);
      cfg = (32'(t) << F_WR_TRAIL) | (32'(a) << F_WR_ACT) | (32'(l) << F_WR_LEAD)
          | (32'(t) << F_RD_TRAIL) | (32'(a) << F_RD_ACT) | (32'(l) << F_RD_LEAD)
          | (32'(ru) << F_READY_USE) | (32'(ra) << F_READY_ASYNC) | (32'(dbl) << F_DOUBLE);
      d = 16'(16'hc350 + z * 16'h0111 + l + a * 16'h1000);
      ready_hold <= 8'(hold);
      reg_wr_t(REG_ZONE_BASE + 8'(4 * z), cfg);
      reg_rd_t(REG_ZONE_BASE + 8'(4 * z), rv);
      cmp(rv, cfg);
      for (int w = 1; w >= 0; w--) begin
         access(w[0], z[ZW-1:0], 19'(19'h2a5a0 + z), d);
         cmp(32'(n_lead), 32'(m * l * s));
         if (ru != 0 && hold != 0) begin
            cmp({31'h0, n_act > m * (a * s + 1)}, 32'h1);
            cmp(32'(n_act % m), 32'h0);
         end else begin
            cmp(32'(n_act), 32'(m * (a * s + 1)));
         end
         cmp(32'(n_trail), 32'(m * t * s));
         cmp(32'(cs_seen), 32'(ecs));
         cmp(32'(addr_seen), 32'(19'h2a5a0 + z));
         cmp(32'(ext_addr), 32'(19'h2a5a0 + z) | 32'h1);
         cmp(32'(oe_seen), 32'(w));
      end
      cmp(32'(acc_rdata), 32'(d));
      reg_rd_t(REG_STATUS, rv);
      if (ru != 0) begin
         cmp(32'(rv[15:8]), 32'(n_act / m - (a * s + 1)));
      end else begin
         cmp(rv, 32'h1);
      end
   endtask

   task automatic clock_check;
      int n;
      logic prev;
      for (int c = 0; c < 4; c++) begin
         reg_wr_t(REG_CLKCFG, 32'(c));
         repeat (8) @(posedge ref_clk);
         #1 prev = ext_bus_clock_out;
         n = 0;
         repeat (32) begin
            @(posedge ref_clk);
            #1 n += int'(ext_bus_clock_out && !prev);
            prev = ext_bus_clock_out;
         end
         cmp(32'(n), 32'(16 >> (c % 2 + c / 2)));
      end
   endtask

   task automatic tally_and_finish;
      $display("checks_done %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // The whole sequence needs only a small part of this span.
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end

   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      acc_valid = 1'b0;
      acc_write = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      acc_zone = 2'h0;
      acc_addr = 19'h0;
      acc_be = 2'h0;
      acc_wdata = 16'h0;
      ready_hold = 8'h00;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      for (int z = 0; z < 3; z++) begin
         reg_rd_t(REG_ZONE_BASE + 8'(4 * z), rv);
         cmp(rv, TIMING_RESET);
      end
      reg_rd_t(REG_CLKCFG, rv);
      cmp(rv, 32'(CLKCFG_RESET));
      reg_rd_t(REG_STATUS, rv);
      cmp(rv, 32'h1);
      reg_wr_t(8'h14, 32'hffff_ffff);
      reg_rd_t(8'h14, rv);
      cmp(rv, 32'h0);
      reg_wr_t(8'h04, 32'hffff_ffff);
      reg_rd_t(8'h04, rv);
      cmp(rv, TIMING_MASK);
      reg_rd_t(8'h00, rv);
      cmp(rv, TIMING_RESET);
      @(posedge ref_clk);
      acc_zone <= 2'h3;
      acc_valid <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 cmp({31'h0, acc_ready}, 32'h0);
      @(posedge ref_clk);
      acc_valid <= 1'b0;
      // Settings below stay within the legal minimums, since nothing checks them.
      zone_test(0, 1, 0, 0, 0, 0, 0, 6, 2);
      zone_test(1, 2, 3, 1, 0, 0, 1, 6, 2);
      zone_test(2, 3, 7, 3, 0, 0, 0, 0, 2);
      zone_test(0, 1, 1, 0, 1, 0, 0, 6, 2);
      zone_test(1, 1, 1, 0, 1, 1, 0, 9, 2);
      zone_test(0, 2, 1, 0, 1, 1, 1, 5, 2);
      reg_wr_t(REG_CLKCFG, 32'h1);
      zone_test(2, 2, 2, 1, 0, 0, 0, 0, 4);
      clock_check();
      tally_and_finish();
   end
endmodule
